/* File: verilog/ddscc_defines.svh */
`ifndef DDSCC_DEFINES_SVH
`define DDSCC_DEFINES_SVH

// Frame layout
`define DDSCC_FRAME_BITS    24
`define DDSCC_RB_UNDEF_BITS 4
`define DDSCC_CNT_SAT       5'h1F

// Command codes
`define DDSCC_CMD_NOP       4'h0
`define DDSCC_CMD_WR_IN     4'h1
`define DDSCC_CMD_UPD       4'h2
`define DDSCC_CMD_WR_UPD    4'h3
`define DDSCC_CMD_PD        4'h4
`define DDSCC_CMD_SW_RST    4'h6
`define DDSCC_CMD_CHAIN     4'h8
`define DDSCC_CMD_RB        4'h9
`define DDSCC_CMD_CHAIN_NOP 4'hF

// Field positions
`define DDSCC_CHAIN_EN_BIT  0

// Reset values
`define DDSCC_CHAIN_RST     1'b0
`define DDSCC_PD_RST        8'h00
`define DDSCC_DAC_RST       16'h0000
`define DDSCC_PIN_IDLE      1'b1

`endif

/* File: verilog/ddscc_pkg.sv */
package ddscc_pkg;

  // One 24-bit serial frame, first bit shifted in at the top
  typedef struct packed {
    logic [3:0]  cmd;
    logic        addr_b;
    logic [1:0]  addr_zero;
    logic        addr_a;
    logic [15:0] data;
  } ddscc_frame_s;

  // Power-down control: 00 normal, 01 1k to ground, 10 100k to ground, 11 open
  typedef struct packed {
    logic       chan_b_pd_hi;
    logic       chan_b_pd_lo;
    logic [3:0] fill;
    logic       chan_a_pd_hi;
    logic       chan_a_pd_lo;
  } ddscc_pd_s;

endpackage

/* File: verilog/ddscc_top.sv */
`timescale 1ns/1ps
`include "ddscc_defines.svh"

// Functional notes
// - Command 1000 bit 0 sets chain enable
// - Reset leaves standalone mode, chain off
// - Shift while selected; overflow ripples to output
// - Output changes on rising serial clock
// - Short or odd frames still accepted
// - Frame end latches, input stops shifting
// - Command 1001 selects readback, data ignored
// - Both or no address reads channel A
// - Next frame shifts selected register out
// - Readback enables output for one frame
// - Four undefined bits, then 16 data
// - Command 0100 loads eight power-down bits
// - Two-bit field selects power-down mode
// - Bits 7:6 channel B, 1:0 channel A
// - Power-down keeps and accepts DAC values
// - Input and DAC register per channel
// - Load low: write updates both registers
// - Load falling edge updates both DACs
// - MSB-first 24-bit frame, falling edge capture
// - Address holds B, two zeros, A
// - Command 1111 is no-op
module ddscc_top #(
  parameter int DAC_W = 16
) (
  input  wire logic                 clk,            // System clock
  input  wire logic                 arst_n,         // Async reset, active low
  input  wire logic                 sclk,           // Serial link clock
  input  wire logic                 frame_sel_n,    // Frame select, active low
  input  wire logic                 serial_in,      // Serial data in
  output logic                      serial_out,     // Serial data out
  output logic                      serial_out_oe,  // Serial out drive enable
  input  wire logic                 load_outputs_n, // Load pin, active low
  output logic                      chain_enable,   // Daisy-chain mode
  output ddscc_pkg::ddscc_pd_s      pd_ctrl,        // Power-down control
  output logic [DAC_W-1:0]          dac_a_code,     // Channel A DAC register
  output logic [DAC_W-1:0]          dac_b_code      // Channel B DAC register
);

  localparam int FB = `DDSCC_FRAME_BITS;

  // ---------------- Serial clock domain ----------------
  logic [FB-1:0] shreg;
  logic [4:0]    bit_cnt;
  logic [FB-1:0] rb_word;
  logic          rb_active;
  wire           rb_bit_sel;
  wire           next_sdo;

  always_ff @(negedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      shreg <= '0;
    end else if (!frame_sel_n) begin
      shreg <= {shreg[FB-2:0], serial_in};
    end
  end

  // Falling edges seen in this frame; cleared while deselected
  // Also cleared in reset, so the first frame counts from zero
  wire cnt_clr = frame_sel_n | ~arst_n;

  always_ff @(negedge sclk or posedge cnt_clr) begin
    if (cnt_clr) begin
      bit_cnt <= '0;
    end else if (bit_cnt != `DDSCC_CNT_SAT) begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  assign rb_bit_sel = rb_word[5'(FB - 1) - bit_cnt];
  // oldest bit ripples out after 24
  assign next_sdo   = (rb_active && (bit_cnt < 5'(FB))) ? rb_bit_sel : shreg[FB-1];

  always_ff @(posedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      serial_out <= 1'b0;
    end else if (!frame_sel_n) begin
      serial_out <= next_sdo;
    end
  end

  // ---------------- System clock domain ----------------
  logic fs_s1, fs_s2, fs_q3;
  logic ld_s1, ld_s2, ld_q3;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fs_s1 <= `DDSCC_PIN_IDLE;
      fs_s2 <= `DDSCC_PIN_IDLE;
      fs_q3 <= `DDSCC_PIN_IDLE;
      ld_s1 <= `DDSCC_PIN_IDLE;
      ld_s2 <= `DDSCC_PIN_IDLE;
      ld_q3 <= `DDSCC_PIN_IDLE;
    end else begin
      fs_s1 <= frame_sel_n;
      fs_s2 <= fs_s1;
      fs_q3 <= fs_s2;
      ld_s1 <= load_outputs_n;
      ld_s2 <= ld_s1;
      ld_q3 <= ld_s2;
    end
  end

  // Shift register is frozen once frame select is high
  wire ddscc_pkg::ddscc_frame_s rx = ddscc_pkg::ddscc_frame_s'(shreg);
  // any clock count closes a frame
  wire fr_end    = fs_s2 & ~fs_q3;
  wire load_outputs_n_fall = ld_q3 & ~ld_s2;

  function automatic logic is_cmd(input logic en, input logic [3:0] cmd, input logic [3:0] code);
    return en & (cmd == code);
  endfunction

  wire [DAC_W-1:0] rx_code = rx.data[15 -: DAC_W];

  wire cmd_wr_in  = is_cmd(fr_end, rx.cmd, `DDSCC_CMD_WR_IN);
  wire cmd_upd    = is_cmd(fr_end, rx.cmd, `DDSCC_CMD_UPD);
  wire cmd_wr_upd = is_cmd(fr_end, rx.cmd, `DDSCC_CMD_WR_UPD);
  wire cmd_pd     = is_cmd(fr_end, rx.cmd, `DDSCC_CMD_PD);
  wire cmd_rst    = is_cmd(fr_end, rx.cmd, `DDSCC_CMD_SW_RST);
  wire cmd_chain  = is_cmd(fr_end, rx.cmd, `DDSCC_CMD_CHAIN);
  wire cmd_rb     = is_cmd(fr_end, rx.cmd, `DDSCC_CMD_RB);

  logic [DAC_W-1:0] in_a, in_b;

  wire wr_in    = cmd_wr_in | cmd_wr_upd;
  wire wr_dac   = cmd_wr_upd | (cmd_wr_in & ~ld_s2);
  // address bits pick B or A
  wire [DAC_W-1:0] next_in_a = (wr_in & rx.addr_a) ? rx_code : in_a;
  wire [DAC_W-1:0] next_in_b = (wr_in & rx.addr_b) ? rx_code : in_b;

  wire [DAC_W-1:0] next_dac_a = (wr_dac & rx.addr_a) ? rx_code :
                                ((cmd_upd & rx.addr_a) | load_outputs_n_fall) ? in_a : dac_a_code;
  wire [DAC_W-1:0] next_dac_b = (wr_dac & rx.addr_b) ? rx_code :
                                ((cmd_upd & rx.addr_b) | load_outputs_n_fall) ? in_b : dac_b_code;

  // only B alone selects channel B
  wire             rb_pick_b = rx.addr_b & ~rx.addr_a;
  wire [15:0]      rb_left   = 16'(rb_pick_b ? dac_b_code : dac_a_code) << (16 - DAC_W);
  wire [FB-1:0]    next_rb_word = {{`DDSCC_RB_UNDEF_BITS{1'b0}}, rb_left, {`DDSCC_RB_UNDEF_BITS{1'b0}}};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      in_a       <= DAC_W'(`DDSCC_DAC_RST);
      in_b       <= DAC_W'(`DDSCC_DAC_RST);
      dac_a_code <= DAC_W'(`DDSCC_DAC_RST);
      dac_b_code <= DAC_W'(`DDSCC_DAC_RST);
    end else if (cmd_rst) begin
      in_a       <= DAC_W'(`DDSCC_DAC_RST);
      in_b       <= DAC_W'(`DDSCC_DAC_RST);
      dac_a_code <= DAC_W'(`DDSCC_DAC_RST);
      dac_b_code <= DAC_W'(`DDSCC_DAC_RST);
    end else begin
      in_a       <= next_in_a;
      in_b       <= next_in_b;
      dac_a_code <= next_dac_a;
      dac_b_code <= next_dac_b;
    end
  end

  // settings move only at frame end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chain_enable <= `DDSCC_CHAIN_RST;
      pd_ctrl      <= ddscc_pkg::ddscc_pd_s'(`DDSCC_PD_RST);
    end else if (cmd_rst) begin
      pd_ctrl      <= ddscc_pkg::ddscc_pd_s'(`DDSCC_PD_RST);
    end else begin
      if (cmd_chain) begin
        chain_enable <= rx.data[`DDSCC_CHAIN_EN_BIT];
      end
      // B in 7:6, A in 1:0
      if (cmd_pd) begin
        pd_ctrl <= ddscc_pkg::ddscc_pd_s'(rx.data[7:0]);
      end
    end
  end

  // every frame other than a readback ends the readback
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rb_active     <= 1'b0;
      rb_word       <= '0;
      serial_out_oe <= 1'b0;
    end else if (fr_end) begin
      rb_active     <= cmd_rb;
      serial_out_oe <= cmd_rb | (cmd_chain ? rx.data[`DDSCC_CHAIN_EN_BIT] : chain_enable);
      if (cmd_rb) begin
        rb_word <= next_rb_word;
      end
    end
  end

  // ---------------- Checks ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_chain_write;
    cmd_chain |=> chain_enable == $past(rx.data[0]);
  endproperty
  a_chain_write: assert property (p_chain_write) else $error("chain enable not loaded");

  property p_reset_standalone;
    $rose(arst_n) |-> !chain_enable && !serial_out_oe;
  endproperty
  a_reset_standalone: assert property (p_reset_standalone) else $error("not standalone after reset");

  property p_rb_oe_on;
    cmd_rb |=> serial_out_oe && rb_active;
  endproperty
  a_rb_oe_on: assert property (p_rb_oe_on) else $error("readback did not enable output");

  property p_rb_oe_off;
    fr_end && !cmd_rb && !cmd_chain && !chain_enable |=> !serial_out_oe && !rb_active;
  endproperty
  a_rb_oe_off: assert property (p_rb_oe_off) else $error("output left on after readback");

  property p_rb_select;
    cmd_rb |=> rb_word[19:4] == ($past(rx.addr_b && !rx.addr_a) ? 16'($past(dac_b_code)) << (16 - DAC_W)
                                                                : 16'($past(dac_a_code)) << (16 - DAC_W));
  endproperty
  a_rb_select: assert property (p_rb_select) else $error("wrong readback register");

  property p_pd_load;
    cmd_pd |=> pd_ctrl == $past(rx.data[7:0]);
  endproperty
  a_pd_load: assert property (p_pd_load) else $error("power-down not loaded");

  property p_pd_frame_only;
    !fr_end |=> $stable(pd_ctrl) && $stable(chain_enable);
  endproperty
  a_pd_frame_only: assert property (p_pd_frame_only) else $error("setting changed mid frame");

  property p_pd_keeps_dac;
    cmd_pd && !load_outputs_n_fall |=> $stable(dac_a_code) && $stable(dac_b_code);
  endproperty
  a_pd_keeps_dac: assert property (p_pd_keeps_dac) else $error("power-down touched DAC");

  property p_load_low_write;
    cmd_wr_in && !ld_s2 && rx.addr_a |=> dac_a_code == $past(rx_code) && in_a == dac_a_code;
  endproperty
  a_load_low_write: assert property (p_load_low_write) else $error("transparent write missed");

  property p_load_high_hold;
    cmd_wr_in && ld_s2 && !load_outputs_n_fall |=> $stable(dac_a_code) && $stable(dac_b_code);
  endproperty
  a_load_high_hold: assert property (p_load_high_hold) else $error("DAC moved with load high");

  property p_load_fall;
    load_outputs_n_fall && !fr_end |=> dac_a_code == $past(in_a) && dac_b_code == $past(in_b);
  endproperty
  a_load_fall: assert property (p_load_fall) else $error("load edge did not update");

  property p_rb_word_quiet;
    !fs_s2 |=> $stable(rb_word) && $stable(rb_active);
  endproperty
  a_rb_word_quiet: assert property (p_rb_word_quiet) else $error("readback word moved in frame");

  property p_load_low_write_b;
    cmd_wr_in && !ld_s2 && rx.addr_b |=> dac_b_code == $past(rx_code) && in_b == dac_b_code;
  endproperty
  a_load_low_write_b: assert property (p_load_low_write_b) else $error("transparent write B missed");

  property p_wr_upd;
    cmd_wr_upd && rx.addr_a |=> dac_a_code == $past(rx_code) && in_a == $past(rx_code);
  endproperty
  a_wr_upd: assert property (p_wr_upd) else $error("write and update missed");

  property p_upd_from_in;
    cmd_upd && rx.addr_b |=> dac_b_code == $past(in_b);
  endproperty
  a_upd_from_in: assert property (p_upd_from_in) else $error("update from input missed");

  property p_sw_reset;
    cmd_rst |=> pd_ctrl == ddscc_pkg::ddscc_pd_s'(`DDSCC_PD_RST) && dac_a_code == DAC_W'(`DDSCC_DAC_RST)
                && dac_b_code == DAC_W'(`DDSCC_DAC_RST) && in_b == DAC_W'(`DDSCC_DAC_RST);
  endproperty
  a_sw_reset: assert property (p_sw_reset) else $error("software reset incomplete");

  property p_oe_follows;
    serial_out_oe == (chain_enable || rb_active);
  endproperty
  a_oe_follows: assert property (p_oe_follows) else $error("output enable out of step");

  property p_rb_one_frame;
    rb_active && fr_end && !cmd_rb |=> !rb_active;
  endproperty
  a_rb_one_frame: assert property (p_rb_one_frame) else $error("readback outlived its frame");

  property p_nop_keeps;
    fr_end && rx.cmd == `DDSCC_CMD_CHAIN_NOP && !load_outputs_n_fall |=> $stable(dac_a_code) && $stable(dac_b_code)
                                                            && $stable(pd_ctrl) && $stable(chain_enable);
  endproperty
  a_nop_keeps: assert property (p_nop_keeps) else $error("no-op changed state");

  property p_in_frame_only;
    !fr_end |=> $stable(in_a) && $stable(in_b);
  endproperty
  a_in_frame_only: assert property (p_in_frame_only) else $error("input register moved mid frame");

  property p_pd_fields;
    cmd_pd |=> {pd_ctrl.chan_b_pd_hi, pd_ctrl.chan_b_pd_lo} == $past(rx.data[7:6])
               && {pd_ctrl.chan_a_pd_hi, pd_ctrl.chan_a_pd_lo} == $past(rx.data[1:0]);
  endproperty
  a_pd_fields: assert property (p_pd_fields) else $error("power-down fields misplaced");

  property p_rb_cmd_keeps;
    cmd_rb && !load_outputs_n_fall |=> $stable(dac_a_code) && $stable(dac_b_code) && $stable(pd_ctrl);
  endproperty
  a_rb_cmd_keeps: assert property (p_rb_cmd_keeps) else $error("readback data bits used");

  property p_rb_lead_zero;
    cmd_rb |=> rb_word[23:20] == 4'h0 && rb_word[3:0] == 4'h0;
  endproperty
  a_rb_lead_zero: assert property (p_rb_lead_zero) else $error("readback framing wrong");

  c_chain_on:  cover property (cmd_chain && rx.data[0]);
  c_readback:  cover property (cmd_rb ##[1:200] fr_end);
  c_deferred:  cover property (cmd_wr_in && ld_s2 ##[1:200] load_outputs_n_fall);
  c_pd_write:  cover property (cmd_pd && rx.data[7:6] == 2'h3);
  c_sw_reset:  cover property (cmd_rst);

endmodule

/* File: verification/ddscc_host_model.sv */
`timescale 1ns/1ps
module ddscc_host (
  output logic      sclk,        // Link clock, still between frames
  output logic      frame_sel_n, // Frame select, active low
  output logic      serial_in,   // Data to device
  input  wire logic serial_out   // Data from device
);
  initial begin
    sclk = 1'b0;
    frame_sel_n = 1'b1;
    serial_in = 1'b0;
  end

  task automatic xfer(input logic [47:0] w, input int n, output logic [47:0] r);
    r = '0;
    frame_sel_n = 1'b0;
    #32;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b1;
      serial_in = w[i];
      #32;
      sclk = 1'b0;
      r[i] = serial_out;
      #32;
    end
    frame_sel_n = 1'b1;
    // Released line shows no stale value
    serial_in = ~serial_in;
    #200;
  endtask
endmodule

/* File: verification/ddscc_top_tb_top.sv */
`timescale 1ns/1ps
module ddscc_top_tb_top;
  logic                 clk;
  logic                 arst_n;
  logic                 load_outputs_n;
  wire                  sclk;
  wire                  frame_sel_n;
  wire                  serial_in;
  logic                 serial_out;
  logic                 serial_out_oe;
  logic                 chain_enable;
  ddscc_pkg::ddscc_pd_s pd_ctrl;
  logic [15:0]          dac_a_code;
  logic [15:0]          dac_b_code;
  logic [41:0]          exp_q[$];
  logic [31:0]          seed;
  logic [47:0]          rb;
  logic [15:0]          da;
  logic [15:0]          db;
  logic [15:0]          d;
  logic [7:0]           pd;
  int                   err_count;
  int                   compares;
  event                 reg_ev;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ddscc_top u_dut (.clk(clk), .arst_n(arst_n), .sclk(sclk), .frame_sel_n(frame_sel_n),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .load_outputs_n(load_outputs_n), .chain_enable(chain_enable), .pd_ctrl(pd_ctrl),
    .dac_a_code(dac_a_code), .dac_b_code(dac_b_code));

  ddscc_host u_host (.sclk(sclk), .frame_sel_n(frame_sel_n), .serial_in(serial_in),
    .serial_out(serial_out));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [47:0] seen, input logic [47:0] want);
    compares++;
    if (seen !== want) begin
      err_count++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic expect_regs(input logic oe, input logic ch, input logic [7:0] p);
    repeat (8) @(posedge clk);
    @(negedge clk);
    exp_q.push_back({oe, ch, p, da, db});
    -> reg_ev;
  endtask

  task automatic load_pulse;
    @(posedge clk);
    load_outputs_n <= 1'b0;
    repeat (4) @(posedge clk);
    load_outputs_n <= 1'b1;
  endtask

  task automatic final_report;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Monitor takes oldest expectation per observation
  initial begin
    forever begin
      @(reg_ev);
      check({6'h0, serial_out_oe, chain_enable, pd_ctrl, dac_a_code, dac_b_code}, {6'h0, exp_q.pop_front()});
    end
  end

  initial begin
    #200000;
    err_count++;
    final_report;
  end

  initial begin
    arst_n = 1'b0;
    load_outputs_n = 1'b1;
    err_count = 0;
    compares = 0;
    seed = 32'h1683966F;
    da = 16'h0000;
    db = 16'h0000;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    expect_regs(1'b0, 1'b0, 8'h00);
    seed = lfsr(seed);
    da = seed[15:0];
    u_host.xfer({24'h0, 8'h31, da}, 24, rb);
    expect_regs(1'b0, 1'b0, 8'h00);
    seed = lfsr(seed);
    d = seed[15:0];
    u_host.xfer({24'h0, 8'h18, d}, 24, rb);
    expect_regs(1'b0, 1'b0, 8'h00);
    load_pulse;
    db = d;
    expect_regs(1'b0, 1'b0, 8'h00);
    @(posedge clk);
    load_outputs_n <= 1'b0;
    seed = lfsr(seed);
    da = seed[15:0];
    u_host.xfer({24'h0, 8'h11, da}, 24, rb);
    expect_regs(1'b0, 1'b0, 8'h00);
    @(posedge clk);
    load_outputs_n <= 1'b1;
    // Fill bits driven high by host
    for (int m = 0; m < 4; m++) begin
      pd = {m[1:0], 4'hF, ~m[1:0]};
      u_host.xfer({24'h0, 8'h40, 8'h00, pd}, 24, rb);
      expect_regs(1'b0, 1'b0, pd);
    end
    seed = lfsr(seed);
    db = seed[15:0];
    u_host.xfer({24'h0, 8'h38, db}, 24, rb);
    expect_regs(1'b0, 1'b0, 8'hFC);
    // Readback B, then both bits selecting A
    for (int k = 0; k < 2; k++) begin
      u_host.xfer({24'h0, 8'h98 | {7'h0, k[0]}, 16'hFFFF}, 24, rb);
      expect_regs(1'b1, 1'b0, 8'hFC);
      u_host.xfer(48'h0, 24, rb);
      check({32'h0, rb[19:4]}, {32'h0, (k == 1) ? da : db});
      expect_regs(1'b0, 1'b0, 8'hFC);
    end
    u_host.xfer({24'h0, 24'h800001}, 24, rb);
    expect_regs(1'b1, 1'b1, 8'hFC);
    seed = lfsr(seed);
    d = seed[15:0];
    u_host.xfer({8'h31, d, 24'hF00000}, 48, rb);
    check({24'h0, rb[23:0]}, {24'h0, 8'h31, d});
    expect_regs(1'b1, 1'b1, 8'hFC);
    // Deferred write, then update from input register
    seed = lfsr(seed);
    d = seed[15:0];
    u_host.xfer({24'h0, 8'h11, d}, 24, rb);
    expect_regs(1'b1, 1'b1, 8'hFC);
    u_host.xfer({24'h0, 24'h210000}, 24, rb);
    da = d;
    expect_regs(1'b1, 1'b1, 8'hFC);
    // Software reset keeps chain mode
    u_host.xfer({24'h0, 24'h600000}, 24, rb);
    da = 16'h0000;
    db = 16'h0000;
    expect_regs(1'b1, 1'b1, 8'h00);
    // Reset in mid run
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    expect_regs(1'b0, 1'b0, 8'h00);
    repeat (2) @(posedge clk);
    final_report;
  end
endmodule
